// File: pkg/crf_regs.svh
`ifndef CRF_REGS_SVH
`define CRF_REGS_SVH

// ----------------------------------------------------------------------------
// register offsets (byte addresses, one aligned word each)
// ----------------------------------------------------------------------------
`define CRF_OFF_CMD     8'h00
`define CRF_OFF_STATUS  8'h04
`define CRF_OFF_FLAGS   8'h08
`define CRF_OFF_ADDR    8'h0C
`define CRF_OFF_FP0     8'h10
`define CRF_OFF_FP1     8'h14
`define CRF_OFF_FL0     8'h18
`define CRF_OFF_FL1     8'h1C
`define CRF_GR_TAG      3'h2
`define CRF_GR_TAG_HI   7
`define CRF_GR_TAG_LO   5

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define CRF_CMD_OP_HI   3
`define CRF_CMD_OP_LO   0
`define CRF_CMD_REG_HI  6
`define CRF_CMD_REG_LO  4
`define CRF_CMD_FSEL    8
`define CRF_FLG_CARRY   0
`define CRF_FLG_LINK    1
`define CRF_FLG_LT      2
`define CRF_FLG_EQ      3
`define CRF_STS_BUSY    4

// ----------------------------------------------------------------------------
// reset values and clear masks (bit 1 is the msb)
// ----------------------------------------------------------------------------
`define CRF_RESET_WORD  32'h0000_0000
`define CRF_MASK_UPPER  32'hFFFF_0000
`define CRF_MASK_LOWER  32'h0000_FFFF
`define CRF_MASK_BYTE1  32'hFF00_0000
`define CRF_MASK_BYTE2  32'h00FF_0000

`endif

// File: pkg/crf_pkg.sv
package crf_pkg;

  typedef enum logic [3:0] {
    CRF_OP_NONE        = 4'h0,
    CRF_OP_CLEAR_FULL  = 4'h1,
    CRF_OP_CLEAR_UPPER = 4'h2,
    CRF_OP_CLEAR_LOWER = 4'h3,
    CRF_OP_CLEAR_BYTE1 = 4'h4,
    CRF_OP_CLEAR_BYTE2 = 4'h5,
    CRF_OP_ZERO_MEM32  = 4'h6,
    CRF_OP_ZERO_MEM16  = 4'h7,
    CRF_OP_ADD_FP      = 4'h8,
    CRF_OP_FL_TO_REG   = 4'h9,
    CRF_OP_REG_TO_FL   = 4'hA
  } crf_op_type;

  typedef logic [31:0] crf_word_type;

endpackage

// File: design/crf_exec.sv
`timescale 1ns/1ns
`include "crf_regs.svh"

module crf_exec (
  input  wire crf_pkg::crf_op_type   op,        // decoded operation
  input  wire crf_pkg::crf_word_type gr_val,    // named general register
  input  wire crf_pkg::crf_word_type fp_val,    // selected field pointer
  input  wire crf_pkg::crf_word_type fl_val,    // selected field length
  output logic                       gr_we,     // general register write
  output crf_pkg::crf_word_type      gr_new,    // its new value
  output logic                       fp_we,     // field pointer write
  output crf_pkg::crf_word_type      fp_new,    // its new value
  output logic                       fl_we,     // field length write
  output crf_pkg::crf_word_type      fl_new,    // its new value
  output logic                       zero_req,  // store zero to memory
  output logic                       zero_half  // 16-bit store
);
  import crf_pkg::*;

  always_comb begin
    gr_we     = 1'b0;
    gr_new    = gr_val;
    fp_we     = 1'b0;
    fp_new    = fp_val + gr_val;
    fl_we     = 1'b0;
    fl_new    = gr_val;
    zero_req  = 1'b0;
    zero_half = 1'b0;
    case (op)
      CRF_OP_CLEAR_FULL: begin
        gr_we  = 1'b1;
        gr_new = `CRF_RESET_WORD;
      end
      CRF_OP_CLEAR_UPPER: begin
        gr_we  = 1'b1;
        gr_new = gr_val & ~`CRF_MASK_UPPER;
      end
      CRF_OP_CLEAR_LOWER: begin
        gr_we  = 1'b1;
        gr_new = gr_val & ~`CRF_MASK_LOWER;
      end
      CRF_OP_CLEAR_BYTE1: begin
        gr_we  = 1'b1;
        gr_new = gr_val & ~`CRF_MASK_BYTE1;
      end
      CRF_OP_CLEAR_BYTE2: begin
        gr_we  = 1'b1;
        gr_new = gr_val & ~`CRF_MASK_BYTE2;
      end
      CRF_OP_ZERO_MEM32: begin
        zero_req = 1'b1;
      end
      CRF_OP_ZERO_MEM16: begin
        zero_req  = 1'b1;
        zero_half = 1'b1;
      end
      CRF_OP_ADD_FP: begin
        fp_we = 1'b1;
      end
      CRF_OP_FL_TO_REG: begin
        gr_we  = 1'b1;
        gr_new = fl_val;
      end
      CRF_OP_REG_TO_FL: begin
        fl_we = 1'b1;
      end
      default: begin
        gr_we = 1'b0;
      end
    endcase
  end

endmodule

// File: design/crf_top.sv
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "crf_regs.svh"

// Functional notes
// - a full clear zeroes all 32 bits of the named register, an upper clear only bits 1-16.
// - a lower clear zeroes bits 17-32 of the named register and keeps bits 1-16.
// - the first byte clear zeroes bits 1-8 and the second bits 9-16, all else kept.
// - zero-memory stores 32 or 16 zero bits at the effective address, no register operand.
// - add-to-field-pointer sums the named register into field pointer 0 or 1.
// - field-length read copies field length 0 or 1 into the named register unchanged.
// - field-length write copies the named register into field length 0 or 1.
module crf_top (
  input  wire logic                  pclk,       // bus clock, 100 MHz
  input  wire logic                  presetn,    // async reset, active low
  input  wire logic                  psel,       // apb select
  input  wire logic                  penable,    // apb access phase
  input  wire logic                  pwrite,     // apb direction
  input  wire logic [7:0]            paddr,      // apb byte address
  input  wire crf_pkg::crf_word_type pwdata,     // apb write data
  output crf_pkg::crf_word_type      prdata,     // apb read data
  output logic                       pready,     // apb ready
  output logic                       pslverr,    // apb error, unmapped
  input  wire logic                  mem_ack,    // memory took the store
  output logic                       mem_req,    // zero store pending
  output crf_pkg::crf_word_type      mem_addr,   // store address
  output crf_pkg::crf_word_type      mem_wdata,  // store data, zero
  output logic                       mem_half    // 16-bit store
);
  import crf_pkg::*;

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  crf_word_type gr [8];
  crf_word_type fp [2];
  crf_word_type fl [2];
  logic [3:0]   flags;
  crf_word_type effective_addr;
  crf_op_type   last_op;

  crf_word_type next_gr [8];
  crf_word_type next_fp [2];
  crf_word_type next_fl [2];
  logic [3:0]   next_flags;
  crf_word_type next_effective_addr;
  crf_op_type   next_last_op;
  crf_word_type next_prdata;
  logic         next_pready;
  logic         next_pslverr;
  logic         next_mem_req;
  crf_word_type next_mem_addr;
  logic         next_mem_half;

  // --------------------------------------------------------------------------
  // command decode and execution
  // --------------------------------------------------------------------------
  logic         done;
  logic         fire;
  crf_op_type   op;
  logic [2:0]   sel;
  logic         fsel;
  crf_word_type sel_val;
  crf_word_type fp_sel_val;
  crf_word_type fl_sel_val;
  logic         gr_we;
  crf_word_type gr_new;
  logic         fp_we;
  crf_word_type fp_new;
  logic         fl_we;
  crf_word_type fl_new;
  logic         zero_req;
  logic         zero_half;

  assign done       = psel & penable & pready;
  assign fire       = done & pwrite & (paddr == `CRF_OFF_CMD);
  assign op         = crf_op_type'(pwdata[`CRF_CMD_OP_HI:`CRF_CMD_OP_LO]);
  assign sel        = pwdata[`CRF_CMD_REG_HI:`CRF_CMD_REG_LO];
  assign fsel       = pwdata[`CRF_CMD_FSEL];
  assign sel_val    = gr[sel];
  assign fp_sel_val = fp[fsel];
  assign fl_sel_val = fl[fsel];

  crf_exec u_exec (
    .op        (op),
    .gr_val    (sel_val),
    .fp_val    (fp_sel_val),
    .fl_val    (fl_sel_val),
    .gr_we     (gr_we),
    .gr_new    (gr_new),
    .fp_we     (fp_we),
    .fp_new    (fp_new),
    .fl_we     (fl_we),
    .fl_new    (fl_new),
    .zero_req  (zero_req),
    .zero_half (zero_half)
  );

  // --------------------------------------------------------------------------
  // next state: bus slave, register file, memory request
  // --------------------------------------------------------------------------
  always_comb begin
    next_gr             = gr;
    next_fp             = fp;
    next_fl             = fl;
    next_flags          = flags;
    next_effective_addr = effective_addr;
    next_last_op        = last_op;
    next_mem_req        = mem_req & ~mem_ack;
    next_mem_addr       = mem_addr;
    next_mem_half       = mem_half;
    next_prdata         = prdata;
    next_pslverr        = pslverr;
    // one wait state: ready is registered so every output is a flop
    next_pready         = psel & penable & ~pready;
    if (psel & penable & ~pready) begin
      next_prdata  = `CRF_RESET_WORD;
      next_pslverr = 1'b0;
      if (paddr == `CRF_OFF_CMD) begin
        next_prdata = {28'h0, last_op};
      end else if (paddr == `CRF_OFF_STATUS) begin
        next_prdata = {27'h0, mem_req, last_op};
      end else if (paddr == `CRF_OFF_FLAGS) begin
        next_prdata = {28'h0, flags};
      end else if (paddr == `CRF_OFF_ADDR) begin
        next_prdata = effective_addr;
      end else if (paddr == `CRF_OFF_FP0) begin
        next_prdata = fp[0];
      end else if (paddr == `CRF_OFF_FP1) begin
        next_prdata = fp[1];
      end else if (paddr == `CRF_OFF_FL0) begin
        next_prdata = fl[0];
      end else if (paddr == `CRF_OFF_FL1) begin
        next_prdata = fl[1];
      end else if (paddr[`CRF_GR_TAG_HI:`CRF_GR_TAG_LO] == `CRF_GR_TAG
                   && paddr[1:0] == 2'b00) begin
        next_prdata = gr[paddr[4:2]];
      end else begin
        next_pslverr = 1'b1;
      end
      if (pwrite) begin
        next_prdata = `CRF_RESET_WORD;
      end
    end
    if (done & pwrite & ~pslverr) begin
      if (paddr == `CRF_OFF_FLAGS) begin
        next_flags = pwdata[3:0];
      end else if (paddr == `CRF_OFF_ADDR) begin
        next_effective_addr = pwdata;
      end else if (paddr == `CRF_OFF_FP0) begin
        next_fp[0] = pwdata;
      end else if (paddr == `CRF_OFF_FP1) begin
        next_fp[1] = pwdata;
      end else if (paddr == `CRF_OFF_FL0) begin
        next_fl[0] = pwdata;
      end else if (paddr == `CRF_OFF_FL1) begin
        next_fl[1] = pwdata;
      end else if (paddr[`CRF_GR_TAG_HI:`CRF_GR_TAG_LO] == `CRF_GR_TAG) begin
        next_gr[paddr[4:2]] = pwdata;
      end
    end
    // flags have no path from execution at all
    if (fire) begin
      next_last_op = op;
      if (gr_we) begin
        next_gr[sel] = gr_new;
      end
      if (fp_we) begin
        next_fp[fsel] = fp_new;
      end
      if (fl_we) begin
        next_fl[fsel] = fl_new;
      end
      // a second zero store while one is pending is dropped, busy shows it
      if (zero_req & ~mem_req) begin
        next_mem_req  = 1'b1;
        next_mem_addr = effective_addr;
        next_mem_half = zero_half;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 8; i++) begin
        gr[i] <= `CRF_RESET_WORD;
      end
      for (int i = 0; i < 2; i++) begin
        fp[i] <= `CRF_RESET_WORD;
        fl[i] <= `CRF_RESET_WORD;
      end
      flags          <= 4'h0;
      effective_addr <= `CRF_RESET_WORD;
      last_op        <= CRF_OP_NONE;
      prdata         <= `CRF_RESET_WORD;
      pready         <= 1'b0;
      pslverr        <= 1'b0;
      mem_req        <= 1'b0;
      mem_addr       <= `CRF_RESET_WORD;
      mem_wdata      <= `CRF_RESET_WORD;
      mem_half       <= 1'b0;
    end else begin
      gr             <= next_gr;
      fp             <= next_fp;
      fl             <= next_fl;
      flags          <= next_flags;
      effective_addr <= next_effective_addr;
      last_op        <= next_last_op;
      prdata         <= next_prdata;
      pready         <= next_pready;
      pslverr        <= next_pslverr;
      mem_req        <= next_mem_req;
      mem_addr       <= next_mem_addr;
      mem_wdata      <= `CRF_RESET_WORD;
      mem_half       <= next_mem_half;
    end
  end

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_zero_cmd(logic half);
    fire && !mem_req && (op == (half ? CRF_OP_ZERO_MEM16 : CRF_OP_ZERO_MEM32));
  endsequence

  sequence s_zero_issue(logic half);
    mem_req && mem_wdata == `CRF_RESET_WORD && mem_half == half
      && mem_addr == $past(effective_addr);
  endsequence

  a_clear_full: assert property (
    fire && op == CRF_OP_CLEAR_FULL |=> gr[$past(sel)] == `CRF_RESET_WORD)
    else $error("full clear left bits set");
  a_clear_upper: assert property (
    fire && op == CRF_OP_CLEAR_UPPER
    |=> (gr[$past(sel)] ^ $past(sel_val)) == ($past(sel_val) & `CRF_MASK_UPPER))
    else $error("upper half clear wrong");
  a_clear_lower: assert property (
    fire && op == CRF_OP_CLEAR_LOWER
    |=> (gr[$past(sel)] ^ $past(sel_val)) == ($past(sel_val) & `CRF_MASK_LOWER))
    else $error("lower half clear wrong");
  a_clear_bytes: assert property (
    fire && (op == CRF_OP_CLEAR_BYTE1 || op == CRF_OP_CLEAR_BYTE2)
    |=> (gr[$past(sel)] ^ $past(sel_val)) == ($past(sel_val)
         & ($past(op) == CRF_OP_CLEAR_BYTE1 ? `CRF_MASK_BYTE1 : `CRF_MASK_BYTE2)))
    else $error("byte clear wrong");
  a_zero_word: assert property (
    s_zero_cmd(1'b0) |=> s_zero_issue(1'b0))
    else $error("fullword zero store not issued");
  a_zero_half: assert property (
    s_zero_cmd(1'b1) |=> s_zero_issue(1'b1))
    else $error("halfword zero store not issued");
  a_req_held: assert property (
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_half))
    else $error("zero store dropped before ack");
  a_field_add: assert property (
    fire && op == CRF_OP_ADD_FP
    |=> fp[$past(fsel)] == $past(fp_sel_val) + $past(sel_val))
    else $error("field pointer sum wrong");
  a_len_read: assert property (
    fire && op == CRF_OP_FL_TO_REG
    |=> gr[$past(sel)] == $past(fl_sel_val) && fl[$past(fsel)] == $past(fl_sel_val))
    else $error("field length read wrong");
  a_len_write: assert property (
    fire && op == CRF_OP_REG_TO_FL
    |=> fl[$past(fsel)] == $past(sel_val) && gr[$past(sel)] == $past(sel_val))
    else $error("field length write wrong");
  a_flags_kept: assert property (
    fire && op >= CRF_OP_CLEAR_FULL && op <= CRF_OP_ZERO_MEM16 |=> $stable(flags))
    else $error("clear changed carry, link or condition bits");

endmodule

// File: test/test_crf_top.sv
`timescale 1ns/1ns
`include "crf_regs.svh"

`define CHECK(name, exp, got) begin \
  cmp_count++; \
  if ((got) !== (exp)) begin \
    failures++; \
    $display("[FAIL] %s expected %h seen %h", name, exp, got); \
  end \
end

module test_crf_top;
  import crf_pkg::*;

  // ----------------------------------------
  // signals and clock
  // ----------------------------------------
  logic         pclk;
  logic         presetn;
  logic         psel;
  logic         penable;
  logic         pwrite;
  logic [7:0]   paddr;
  crf_word_type pwdata;
  crf_word_type prdata;
  logic         pready;
  logic         pslverr;
  logic         mem_ack;
  logic         mem_req;
  crf_word_type mem_addr;
  crf_word_type mem_wdata;
  logic         mem_half;
  int           failures;
  int           cmp_count;
  crf_word_type flg;
  crf_word_type rq;
  logic         re;
  crf_op_type   ops [5] = '{CRF_OP_CLEAR_FULL, CRF_OP_CLEAR_UPPER, CRF_OP_CLEAR_LOWER,
                            CRF_OP_CLEAR_BYTE1, CRF_OP_CLEAR_BYTE2};
  crf_word_type masks [5] = '{32'hFFFF_FFFF, `CRF_MASK_UPPER, `CRF_MASK_LOWER,
                              `CRF_MASK_BYTE1, `CRF_MASK_BYTE2};

  crf_top dut (
    .pclk      (pclk),
    .presetn   (presetn),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .paddr     (paddr),
    .pwdata    (pwdata),
    .prdata    (prdata),
    .pready    (pready),
    .pslverr   (pslverr),
    .mem_ack   (mem_ack),
    .mem_req   (mem_req),
    .mem_addr  (mem_addr),
    .mem_wdata (mem_wdata),
    .mem_half  (mem_half)
  );

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  // each transfer starts one edge after the last release, so no signal is driven twice
  task automatic apb(input logic wr, input logic [7:0] a, input crf_word_type d,
                     output crf_word_type q, output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    `CHECK("pready", 1'b1, pready)
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input crf_word_type d);
    crf_word_type q;
    logic         e;
    apb(1'b1, a, d, q, e);
    `CHECK("write error", 1'b0, e)
  endtask

  task automatic rd(input string name, input logic [7:0] a, input crf_word_type exp);
    crf_word_type q;
    logic         e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    `CHECK(name, exp, q)
  endtask

  task automatic cmd(input crf_op_type op, input logic [2:0] r, input logic sel);
    wr(`CRF_OFF_CMD, {23'h000000, sel, 1'b0, r, op});
  endtask

  function automatic logic [7:0] gra(input logic [2:0] n);
    return 8'h40 + {3'h0, n, 2'b00};
  endfunction

  task automatic zmem(input crf_op_type op, input logic half, input crf_word_type ea);
    int           n;
    crf_word_type q;
    logic         e;
    wr(`CRF_OFF_ADDR, ea);
    wr(`CRF_OFF_FLAGS, 32'h0000_000F);
    wr(gra(0), 32'h0BAD_F00D);
    cmd(op, 3'h0, 1'b0);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (mem_req !== 1'b1 && n < 20);
    `CHECK("mem_req", 1'b1, mem_req)
    `CHECK("mem_addr", ea, mem_addr)
    `CHECK("mem_wdata", `CRF_RESET_WORD, mem_wdata)
    `CHECK("mem_half", half, mem_half)
    // store held pending while status is read, so busy must show
    apb(1'b0, `CRF_OFF_STATUS, 32'h0000_0000, q, e);
    `CHECK("busy", 1'b1, q[`CRF_STS_BUSY])
    `CHECK("status op", op, q[3:0])
    `CHECK("mem_req held", 1'b1, mem_req)
    mem_ack <= 1'b1;
    @(posedge pclk);
    mem_ack <= 1'b0;
    @(posedge pclk);
    `CHECK("mem_req done", 1'b0, mem_req)
    rd("flags after zero", `CRF_OFF_FLAGS, 32'h0000_000F);
    rd("gr0 untouched", gra(0), 32'h0BAD_F00D);
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    #200000;
    failures++;
    $display("[FAIL] watchdog expected end seen timeout");
    complete_run();
  end

  initial begin
    failures = 0;
    cmp_count = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    mem_ack = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rd("gr reset", gra(3'(i)), `CRF_RESET_WORD);
    end
    rd("fp1 reset", `CRF_OFF_FP1, `CRF_RESET_WORD);
    rd("fl1 reset", `CRF_OFF_FL1, `CRF_RESET_WORD);
    // alternating flag patterns catch a clear that touches any flag bit
    for (int i = 0; i < 5; i++) begin
      flg = (i % 2 == 1) ? 32'h0000_0005 : 32'h0000_000A;
      wr(gra(3'(i + 2)), 32'hA5C3_96E1);
      wr(gra(1), 32'hA5C3_96E1);
      wr(`CRF_OFF_FLAGS, flg);
      cmd(ops[i], 3'(i + 2), 1'b0);
      rd("gr cleared", gra(3'(i + 2)), 32'hA5C3_96E1 & ~masks[i]);
      rd("gr neighbour", gra(1), 32'hA5C3_96E1);
      rd("flags after clear", `CRF_OFF_FLAGS, flg);
    end
    zmem(CRF_OP_ZERO_MEM32, 1'b0, 32'h0000_1234);
    zmem(CRF_OP_ZERO_MEM16, 1'b1, 32'h0000_ABCE);
    // pointer 1 wraps past the top of the word
    wr(`CRF_OFF_FP0, 32'h1000_0010);
    wr(`CRF_OFF_FP1, 32'hFFFF_FF00);
    wr(gra(3), 32'h0000_0105);
    cmd(CRF_OP_ADD_FP, 3'h3, 1'b1);
    rd("fp1 sum", `CRF_OFF_FP1, 32'h0000_0005);
    rd("fp0 kept", `CRF_OFF_FP0, 32'h1000_0010);
    cmd(CRF_OP_ADD_FP, 3'h3, 1'b0);
    rd("fp0 sum", `CRF_OFF_FP0, 32'h1000_0115);
    rd("gr3 kept", gra(3), 32'h0000_0105);
    wr(`CRF_OFF_FL0, 32'h0000_0011);
    wr(`CRF_OFF_FL1, 32'h0000_0022);
    cmd(CRF_OP_FL_TO_REG, 3'h5, 1'b1);
    cmd(CRF_OP_FL_TO_REG, 3'h6, 1'b0);
    rd("gr5 from fl1", gra(5), 32'h0000_0022);
    rd("gr6 from fl0", gra(6), 32'h0000_0011);
    rd("fl1 kept", `CRF_OFF_FL1, 32'h0000_0022);
    wr(gra(7), 32'hCAFE_0007);
    cmd(CRF_OP_REG_TO_FL, 3'h7, 1'b0);
    rd("fl0 from gr7", `CRF_OFF_FL0, 32'hCAFE_0007);
    rd("fl1 untouched", `CRF_OFF_FL1, 32'h0000_0022);
    rd("gr7 kept", gra(7), 32'hCAFE_0007);
    rd("last op", `CRF_OFF_CMD, 32'h0000_000A);
    // an undefined code is a no-op that still records itself as the last command
    cmd(crf_op_type'(4'hB), 3'h7, 1'b1);
    rd("gr7 after no-op", gra(7), 32'hCAFE_0007);
    rd("fl1 after no-op", `CRF_OFF_FL1, 32'h0000_0022);
    rd("last op no-op", `CRF_OFF_CMD, 32'h0000_000B);
    rd("addr kept", `CRF_OFF_ADDR, 32'h0000_ABCE);
    // unmapped and misaligned accesses answer with an error and change nothing
    apb(1'b0, 8'h20, 32'h0000_0000, rq, re);
    `CHECK("unmapped read error", 1'b1, re)
    `CHECK("unmapped read data", `CRF_RESET_WORD, rq)
    apb(1'b1, 8'h41, 32'hFFFF_FFFF, rq, re);
    `CHECK("misaligned write error", 1'b1, re)
    rd("gr0 after misaligned", gra(0), 32'h0BAD_F00D);
    complete_run();
  end
endmodule
